// >>> smb_pkg.sv
package smb_pkg;
  localparam logic [3:0] ADDR_PREFIX   = 4'hA;
  localparam logic [7:0] CMD_BLK_WR    = 8'h94;
  localparam logic [7:0] CMD_BLK_RD    = 8'h95;
  localparam logic [7:0] CMD_REBOOT    = 8'h96;
  localparam logic [7:0] CMD_FSTORE    = 8'h97;
  localparam logic [7:0] CMD_EXT_ON    = 8'h98;
  localparam logic [7:0] CMD_EXT_OFF   = 8'h99;
  localparam logic [7:0] CMD_EE_ON     = 8'h9A;
  localparam logic [7:0] CMD_EE_OFF    = 8'h9B;
  localparam logic [7:0] BOOT_FIRST    = 8'h0F;
  localparam logic [7:0] BOOT_LAST     = 8'h7D;
  localparam logic [7:0] CFG_LAST      = 8'h7D;
  localparam logic [7:0] EE_LAST       = 8'hFF;
  localparam logic [7:0] BLK_RD_COUNT  = 8'h10;
  localparam logic [4:0] BLK_WR_MAX    = 5'h10;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam int         SCL_MAX_KHZ   = 400;
  localparam int         MCLK_MHZ      = 50;
  localparam int         SCL_HALF_CYC  = (MCLK_MHZ * 1000) / (2 * SCL_MAX_KHZ);

  typedef enum logic [1:0] {
    SMB_PG_DEF = 2'h0,
    SMB_PG_EXT = 2'h1,
    SMB_PG_EE  = 2'h2
  } smb_page_e;

  typedef enum logic [8:0] {
    SMB_IDLE  = 9'h001,
    SMB_ADDR  = 9'h002,
    SMB_AACK  = 9'h004,
    SMB_RXB   = 9'h008,
    SMB_RACK  = 9'h010,
    SMB_TXB   = 9'h020,
    SMB_TACK  = 9'h040,
    SMB_BOOT  = 9'h080,
    SMB_WAIT  = 9'h100
  } smb_state_e;

  // memory port toward the register file
  typedef struct packed {
    logic      wr;
    logic      rd;
    smb_page_e page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } smb_mem_req_s;

  // link side samples and events
  typedef struct packed {
    logic scl;
    logic sda;
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } smb_link_s;
endpackage : smb_pkg

// >>> smb_line_sync.sv
module smb_line_sync (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // raw lines
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  // events
  output smb_pkg::smb_link_s link
);
  typedef struct packed {
    logic [1:0] scl_m;
    logic [1:0] sda_m;
    smb_pkg::smb_link_s lk;
  } smb_sync_s;

  smb_sync_s s_q;
  smb_sync_s s_d;

  always_comb begin
    s_d          = s_q;
    s_d.scl_m    = {s_q.scl_m[0], scl_in};
    s_d.sda_m    = {s_q.sda_m[0], sda_in};
    s_d.lk.scl   = s_q.scl_m[1];
    s_d.lk.sda   = s_q.sda_m[1];
    s_d.lk.rise  = s_q.scl_m[1] & ~s_q.lk.scl;
    s_d.lk.fall  = ~s_q.scl_m[1] & s_q.lk.scl;
    s_d.lk.start = s_q.lk.scl & s_q.scl_m[1] & s_q.lk.sda & ~s_q.sda_m[1];
    s_d.lk.stop  = s_q.lk.scl & s_q.scl_m[1] & ~s_q.lk.sda & s_q.sda_m[1];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '{scl_m: 2'h3, sda_m: 2'h3, lk: '{scl: 1'b1, sda: 1'b1, start: 1'b0, stop: 1'b0,
               rise: 1'b0, fall: 1'b0}};
    end else begin
      s_q <= s_d;
    end
  end

  assign link = s_q.lk;
endmodule : smb_line_sync

// >>> smb_slave_port.sv
module smb_slave_port #(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // bus pins
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  // address select pin states, pre-decoded: gnd, high, scl, sda
  input  wire logic [1:0]          addr_select_pin,
  // status from the rest of the device
  input  wire logic                ee_busy,
  input  wire logic [7:0]          mem_rdata,
  input  wire logic                mem_valid,
  // memory request
  output smb_pkg::smb_mem_req_s    mem_req,
  // command pulses, boot status and pointer
  output logic                     reboot_start,
  output logic                     fault_store,
  output logic                     boot_busy,
  output logic [7:0]               ptr
);
  if (SYNC_STAGES != 2) begin : g_sync_check
    $error("smb_slave_port supports two sync stages only");
  end

  typedef struct packed {
    smb_pkg::smb_state_e st;
    smb_pkg::smb_page_e  page;
    logic [7:0]          sh;
    logic [3:0]          cnt;
    logic                rw;
    logic [7:0]          ptr;
    logic [7:0]          cmd;
    logic                have_cmd;
    logic                blk_wr;
    logic                blk_rd;
    logic [4:0]          blk_left;
    logic                blk_cnt_sent;
    logic                ack;
    logic                sda_low;
    logic [6:0]          addr_sel;
    logic                reboot;
    logic                fstore;
    logic [7:0]          boot_a;
    logic                boot_on;
    logic                tx_cnt;
    logic [1:0]          pin_a;
    logic [1:0]          pin_b;
    smb_pkg::smb_mem_req_s req;
  } smb_port_s;

  smb_pkg::smb_link_s lk;
  smb_port_s s_q;
  smb_port_s s_d;

  smb_line_sync u_sync (
    .mclk   (mclk),
    .rst    (rst),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .link   (lk)
  );

  function automatic logic addr_ok(input smb_pkg::smb_page_e pg, input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    case (pg)
      smb_pkg::SMB_PG_EE:  ok = 1'b1;
      smb_pkg::SMB_PG_DEF: ok = (a <= smb_pkg::CFG_LAST);
      smb_pkg::SMB_PG_EXT: ok = (a <= smb_pkg::CFG_LAST);
      default:             ok = 1'b0;
    endcase
    return ok;
  endfunction : addr_ok

  function automatic logic [7:0] ptr_inc(input smb_pkg::smb_page_e pg, input logic [7:0] a);
    logic [7:0] lim;
    lim = (pg == smb_pkg::SMB_PG_EE) ? smb_pkg::EE_LAST : smb_pkg::CFG_LAST;
    return (a >= lim) ? lim : 8'(a + 8'h01);
  endfunction : ptr_inc

  always_comb begin
    s_d         = s_q;
    s_d.req.wr  = 1'b0;
    s_d.req.rd  = 1'b0;
    s_d.reboot  = 1'b0;
    s_d.fstore  = 1'b0;
    s_d.pin_a   = addr_select_pin;
    s_d.pin_b   = s_q.pin_a;
    case (s_q.st)
      smb_pkg::SMB_IDLE: begin
        s_d.sda_low = 1'b0;
      end
      smb_pkg::SMB_ADDR: begin
        if (lk.rise) begin
          s_d.sh  = {s_q.sh[6:0], lk.sda};
          s_d.cnt = 4'(s_q.cnt + 4'h1);
        end
        if (lk.fall && s_q.cnt == 4'h8) begin
          if (s_q.sh[7:4] == smb_pkg::ADDR_PREFIX && s_q.sh[3:2] == s_q.pin_b) begin
            s_d.rw      = s_q.sh[0];
            s_d.sda_low = 1'b1;
            s_d.st      = smb_pkg::SMB_AACK;
            s_d.req.rd  = s_q.sh[0];
            s_d.req.addr = s_q.ptr;
            s_d.req.page = s_q.page;
          end else begin
            s_d.st = smb_pkg::SMB_WAIT;
          end
        end
      end
      smb_pkg::SMB_AACK: begin
        if (lk.fall) begin
          s_d.cnt = 4'h0;
          if (s_q.rw) begin
            s_d.st  = smb_pkg::SMB_TXB;
            s_d.sh  = (s_q.blk_rd && !s_q.blk_cnt_sent) ? smb_pkg::BLK_RD_COUNT : mem_rdata;
            s_d.blk_cnt_sent = s_q.blk_rd;
            s_d.tx_cnt  = s_q.blk_rd && !s_q.blk_cnt_sent;
            s_d.sda_low = (s_q.blk_rd && !s_q.blk_cnt_sent) ? ~smb_pkg::BLK_RD_COUNT[7] : ~mem_rdata[7];
          end else begin
            s_d.sda_low = 1'b0;
            s_d.st      = smb_pkg::SMB_RXB;
          end
        end
      end
      smb_pkg::SMB_RXB: begin
        if (lk.rise) begin
          s_d.sh  = {s_q.sh[6:0], lk.sda};
          s_d.cnt = 4'(s_q.cnt + 4'h1);
        end
        if (lk.fall && s_q.cnt == 4'h8) begin
          s_d.st  = smb_pkg::SMB_RACK;
          s_d.ack = 1'b1;
          if (!s_q.have_cmd) begin
            s_d.cmd = s_q.sh;
            if (ee_busy || s_q.boot_a != smb_pkg::PTR_RESET) begin
              s_d.ack = 1'b0;
            end else if (s_q.sh == smb_pkg::CMD_BLK_WR || s_q.sh == smb_pkg::CMD_BLK_RD) begin
              s_d.ack = 1'b1;
            end else if (s_q.sh[7:4] == 4'h9 && s_q.sh >= smb_pkg::CMD_REBOOT && s_q.sh <= smb_pkg::CMD_EE_OFF) begin
              s_d.ack = 1'b1;
            end else begin
              s_d.ack = addr_ok(s_q.page, s_q.sh);
            end
          end else if (s_q.blk_wr && s_q.blk_left == 5'h0) begin
            s_d.ack = (s_q.sh != 8'h00) && (s_q.sh <= 8'(smb_pkg::BLK_WR_MAX));
          end
          s_d.sda_low = s_d.ack;
        end
      end
      smb_pkg::SMB_RACK: begin
        if (lk.fall) begin
          s_d.sda_low = 1'b0;
          s_d.cnt     = 4'h0;
          s_d.st      = s_q.ack ? smb_pkg::SMB_RXB : smb_pkg::SMB_WAIT;
          if (s_q.ack && !s_q.have_cmd) begin
            s_d.have_cmd = 1'b1;
            case (s_q.cmd)
              smb_pkg::CMD_BLK_WR:  s_d.blk_wr = 1'b1;
              smb_pkg::CMD_BLK_RD:  s_d.blk_rd = 1'b1;
              smb_pkg::CMD_REBOOT:  begin
                s_d.st     = smb_pkg::SMB_WAIT;
                s_d.boot_a = smb_pkg::BOOT_FIRST;
                s_d.ptr    = smb_pkg::PTR_RESET;
                s_d.reboot = 1'b1;
              end
              smb_pkg::CMD_FSTORE:  s_d.fstore = 1'b1;
              smb_pkg::CMD_EXT_ON:  s_d.page = smb_pkg::SMB_PG_EXT;
              smb_pkg::CMD_EXT_OFF: s_d.page = smb_pkg::SMB_PG_DEF;
              smb_pkg::CMD_EE_ON:   s_d.page = smb_pkg::SMB_PG_EE;
              smb_pkg::CMD_EE_OFF:  s_d.page = smb_pkg::SMB_PG_DEF;
              default:              s_d.ptr = s_q.cmd;
            endcase
          end else if (s_q.ack && s_q.blk_wr && s_q.blk_left == 5'h0) begin
            s_d.blk_left = s_q.sh[4:0];
          end else if (s_q.ack) begin
            s_d.req.wr    = 1'b1;
            s_d.req.addr  = s_q.ptr;
            s_d.req.wdata = s_q.sh;
            s_d.req.page  = s_q.page;
            s_d.ptr       = ptr_inc(s_q.page, s_q.ptr);
            if (s_q.blk_wr) begin
              s_d.blk_left = 5'(s_q.blk_left - 5'h1);
              if (s_q.blk_left == 5'h1) s_d.st = smb_pkg::SMB_WAIT;
            end else begin
              s_d.st = smb_pkg::SMB_WAIT;
            end
          end
        end
      end
      smb_pkg::SMB_TXB: begin
        if (lk.fall) begin
          s_d.cnt = 4'(s_q.cnt + 4'h1);
          if (s_q.cnt == 4'h7) begin
            s_d.sda_low = 1'b0;
            s_d.st      = smb_pkg::SMB_TACK;
            if (!s_q.tx_cnt) begin
              s_d.ptr = ptr_inc(s_q.page, s_q.ptr);
            end
          end else begin
            s_d.sh      = {s_q.sh[6:0], 1'b0};
            s_d.sda_low = ~s_q.sh[6];
          end
        end
      end
      smb_pkg::SMB_TACK: begin
        if (lk.rise) begin
          s_d.ack = ~lk.sda;
          if (!lk.sda) begin
            s_d.req.rd   = 1'b1;
            s_d.req.addr = s_q.ptr;
            s_d.req.page = s_q.page;
          end
        end
        if (lk.fall) begin
          s_d.cnt = 4'h0;
          if (s_q.ack) begin
            s_d.st      = smb_pkg::SMB_TXB;
            s_d.tx_cnt  = 1'b0;
            s_d.sh      = mem_rdata;
            s_d.sda_low = ~mem_rdata[7];
          end else begin
            s_d.st = smb_pkg::SMB_WAIT;
          end
        end
      end
      smb_pkg::SMB_BOOT: begin
        s_d.st = smb_pkg::SMB_IDLE;
      end
      smb_pkg::SMB_WAIT: begin
        s_d.sda_low = 1'b0;
      end
      default: begin
        s_d.st = smb_pkg::SMB_IDLE;
      end
    endcase
    if (s_q.boot_a != smb_pkg::PTR_RESET && mem_valid) begin
      s_d.req.rd   = 1'b1;
      s_d.req.wr   = 1'b0;
      s_d.req.addr = s_q.boot_a;
      s_d.req.page = smb_pkg::SMB_PG_DEF;
      s_d.boot_a   = (s_q.boot_a == smb_pkg::BOOT_LAST) ? smb_pkg::PTR_RESET : 8'(s_q.boot_a + 8'h01);
      if (s_q.boot_a == smb_pkg::BOOT_LAST) s_d.page = smb_pkg::SMB_PG_DEF;
    end
    // stays high through the cycle that carries the last boot read
    s_d.boot_on = (s_q.boot_a != smb_pkg::PTR_RESET);
    if (lk.start) begin
      s_d.st       = smb_pkg::SMB_ADDR;
      s_d.cnt      = 4'h0;
      s_d.sda_low  = 1'b0;
      s_d.have_cmd = s_q.have_cmd & (s_q.blk_rd | s_q.st == smb_pkg::SMB_RXB);
    end else if (lk.stop && s_q.st != smb_pkg::SMB_ADDR) begin
      s_d.st       = smb_pkg::SMB_IDLE;
      s_d.sda_low  = 1'b0;
      s_d.have_cmd = 1'b0;
      s_d.blk_wr   = 1'b0;
      s_d.blk_rd   = 1'b0;
      s_d.blk_cnt_sent = 1'b0;
      s_d.blk_left = 5'h0;
    end else if (lk.stop) begin
      s_d.st      = smb_pkg::SMB_IDLE;
      s_d.sda_low = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q        <= '0;
      s_q.st     <= smb_pkg::SMB_IDLE;
      s_q.page   <= smb_pkg::SMB_PG_DEF;
      s_q.ptr    <= smb_pkg::PTR_RESET;
      s_q.boot_a <= smb_pkg::BOOT_FIRST;
      s_q.boot_on <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs from flip-flops, sda_out tied to 0; sda only pulls low
  assign sda_out      = 1'b0;
  assign sda_oe       = s_q.sda_low;
  assign mem_req      = s_q.req;
  assign reboot_start = s_q.reboot;
  assign fault_store  = s_q.fstore;
  assign boot_busy    = s_q.boot_on;
  assign ptr          = s_q.ptr;
endmodule : smb_slave_port

// >>> smb_slave_port_properties.sv
module smb_slave_port_properties (
  // clock and reset
  input wire logic             mclk,
  input wire logic             rst,
  // bus pins
  input wire logic             scl_in,
  input wire logic             sda_out,
  input wire logic             sda_oe,
  // device side
  input wire logic             mem_valid,
  input smb_pkg::smb_mem_req_s mem_req,
  input wire logic             reboot_start,
  input wire logic             fault_store,
  input wire logic             boot_busy
);
  logic [7:0] boot_cnt_q;
  logic [7:0] boot_cnt_d;

  // counts boot copy cycles that the memory accepted
  always_comb boot_cnt_d = boot_busy ? boot_cnt_q + 8'(mem_valid) : 8'h00;
  always_ff @(posedge mclk) boot_cnt_q <= rst ? 8'h00 : boot_cnt_d;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_sda_low_only: assert property (sda_out == 1'b0) else $error("sda driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved with scl high");
  a_reboot_once: assert property (reboot_start |=> !reboot_start) else $error("reboot pulse long");
  a_fstore_once: assert property (fault_store |=> !fault_store) else $error("fault store pulse long");
  a_boot_after: assert property (reboot_start |-> ##[0:4] boot_busy) else $error("no boot after reboot");
  a_boot_span: assert property (boot_busy && mem_req.rd |->
    mem_req.addr inside {[8'h0F:8'h7D]} && mem_req.page == smb_pkg::SMB_PG_DEF) else $error("boot read out of range");
  a_boot_len: assert property (boot_cnt_q <= 8'h77) else $error("boot copy too long");
  a_wr_valid: assert property (mem_req.wr && mem_req.page != smb_pkg::SMB_PG_EE |->
    mem_req.addr <= 8'h7D) else $error("write to bad address");
  a_boot_quiet: assert property (boot_busy |-> !mem_req.wr && !fault_store) else $error("bus acted in boot");
  a_wr_pulse: assert property (mem_req.wr |=> !mem_req.wr) else $error("write pulse long");
endmodule : smb_slave_port_properties

bind smb_slave_port smb_slave_port_properties i_smb_slave_port_properties (
  .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .mem_valid(mem_valid),
  .mem_req(mem_req), .reboot_start(reboot_start), .fault_store(fault_store), .boot_busy(boot_busy));

// >>> smb_master_model.sv
module smb_master_model #(
  parameter int H = 10
) (
  // link clock
  input  wire logic lk,
  // wired bus level
  input  wire logic sda,
  // master drive
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus released and high between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // half scl period, under 400 kHz for H of 10 or more
  task automatic half();
    repeat (H) @(posedge lk);
  endtask : half

  // start or repeated start: sda falls while scl high
  task automatic start();
    sda_pull <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b1;
    half();
    scl <= 1'b0;
  endtask : start

  // stop: sda rises while scl high, always after some clock pulses
  task automatic stop();
    @(posedge lk);
    sda_pull <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b0;
    half();
  endtask : stop

  // one clock pulse: data set while scl low, sampled at end of high
  task automatic bit_x(input logic b, output logic s);
    @(posedge lk);
    sda_pull <= !b;
    half();
    scl <= 1'b1;
    half();
    s = sda;
    scl <= 1'b0;
  endtask : bit_x

  // byte out msb first, ninth clock samples the acknowledge
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask : put

  // byte in; master answers ack, or nack on the last byte
  task automatic get(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(!mack, s);
  endtask : get
endmodule : smb_master_model

// >>> test_i2c_smbus_slave_port.sv
module test_i2c_smbus_slave_port;
  timeunit 1ns;
  timeprecision 100ps;
  // clocks and bus
  logic                  mclk;
  logic                  lk;
  logic                  rst;
  logic                  scl;
  logic                  sda;
  logic                  sda_pull;
  logic                  sda_out;
  logic                  sda_oe;
  // device side
  logic [1:0]            pin = 2'h0;
  logic                  ee_busy = 1'b0;
  logic [7:0]            mem_rdata = 8'h00;
  smb_pkg::smb_mem_req_s mem_req;
  logic                  reboot_start;
  logic                  fault_store;
  logic                  boot_busy;
  logic [7:0]            ptr;
  // records
  logic [7:0]            wa;
  logic [7:0]            wd;
  smb_pkg::smb_page_e    wp;
  int                    nwr, nrb, nfs, nbr, cyc, miscompares, compares;

  smb_master_model #(.H(10)) i_smb_master_model (.lk(lk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  smb_slave_port #(.SYNC_STAGES(2)) i_smb_slave_port (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(pin), .ee_busy(ee_busy), .mem_rdata(mem_rdata),
    .mem_valid(1'b1), .mem_req(mem_req), .reboot_start(reboot_start), .fault_store(fault_store),
    .boot_busy(boot_busy), .ptr(ptr));

  // pull-up wire
  assign sda = !sda_pull && (sda_oe ? sda_out : 1'b1);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    lk = 1'b0;
    #7;
    forever #62.5 lk = ~lk;
  end

  // memory answers addr ^ 5A, and events are counted
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (mem_req.rd) mem_rdata <= #1 mem_req.addr ^ 8'h5A;
    if (mem_req.wr) begin
      wa <= mem_req.addr;
      wd <= mem_req.wdata;
      wp <= mem_req.page;
      nwr <= nwr + 1;
    end
    if (mem_req.rd && boot_busy) nbr <= nbr + 1;
    nrb <= nrb + int'(reboot_start);
    nfs <= nfs + int'(fault_store);
    if (cyc == 95000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic boot_wait();
    repeat (6) @(posedge mclk);
    for (int i = 0; i < 400 && boot_busy !== 1'b0; i++) @(posedge mclk);
    chk("boot_busy", 8'h00, 8'(boot_busy));
  endtask : boot_wait

  task automatic hdr(input logic [1:0] q, input logic rw, output logic a);
    i_smb_master_model.start();
    i_smb_master_model.put({4'hA, q, q[0], rw}, a);
  endtask : hdr

  task automatic send(input logic [7:0] c, input logic [7:0] d, input logic two, output logic a);
    logic h;
    hdr(pin, 1'b0, h);
    i_smb_master_model.put(c, a);
    if (a && two) i_smb_master_model.put(d, h);
    i_smb_master_model.stop();
  endtask : send

  task automatic t_addr();
    logic a;
    for (int p = 0; p < 4; p++) begin
      @(posedge mclk);
      pin <= #1 2'(p);
      hdr(2'(p), 1'b0, a);
      i_smb_master_model.stop();
      chk("addr_ack", 8'h01, 8'(a));
      hdr(~2'(p), 1'b0, a);
      i_smb_master_model.stop();
      chk("addr_nack", 8'h00, 8'(a));
    end
  endtask : t_addr

  task automatic t_send();
    logic a;
    send(8'h05, 8'h00, 1'b0, a);
    chk("send_ack", 8'h01, 8'(a));
    chk("ptr", 8'h05, ptr);
    send(8'h7E, 8'h00, 1'b0, a);
    chk("bad_nack", 8'h00, 8'(a));
    @(posedge mclk);
    ee_busy <= #1 1'b1;
    send(8'h06, 8'h00, 1'b0, a);
    chk("busy_nack", 8'h00, 8'(a));
    @(posedge mclk);
    ee_busy <= #1 1'b0;
    hdr(pin, 1'b0, a);
    for (int i = 0; i < 4; i++) i_smb_master_model.bit_x(1'b0, a);
    i_smb_master_model.stop();
    chk("ptr", 8'h05, ptr);
  endtask : t_send

  task automatic t_page();
    logic a;
    int n;
    logic [7:0] cm [4] = '{8'h98, 8'h99, 8'h9A, 8'h9B};
    logic [7:0] ad [4] = '{8'h30, 8'h31, 8'hF0, 8'h32};
    logic [1:0] pg [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
    for (int i = 0; i < 4; i++) begin
      send(cm[i], 8'h00, 1'b0, a);
      chk("cmd_ack", 8'h01, 8'(a));
      n = nwr;
      send(ad[i], 8'(i) ^ 8'hC3, 1'b1, a);
      chk("wr_cnt", 8'(n + 1), 8'(nwr));
      chk("wr_addr", ad[i], wa);
      chk("wr_data", 8'(i) ^ 8'hC3, wd);
      chk("wr_page", 8'(pg[i]), 8'(wp));
    end
    send(8'hF0, 8'h11, 1'b1, a);
    chk("wr_bad", 8'h00, 8'(a));
  endtask : t_page

  task automatic t_read();
    logic a;
    logic [7:0] d;
    hdr(pin, 1'b0, a);
    i_smb_master_model.put(8'h20, a);
    hdr(pin, 1'b1, a);
    i_smb_master_model.get(1'b0, d);
    i_smb_master_model.stop();
    chk("rd_byte", 8'h7A, d);
    chk("ptr", 8'h21, ptr);
    hdr(pin, 1'b1, a);
    i_smb_master_model.get(1'b0, d);
    i_smb_master_model.stop();
    chk("rx_byte", 8'h7B, d);
    chk("ptr", 8'h22, ptr);
    send(8'h90, 8'h00, 1'b0, a);
    chk("rd_nack", 8'h00, 8'(a));
    chk("ptr", 8'h22, ptr);
  endtask : t_read

  task automatic t_cmds();
    logic a;
    logic [7:0] d;
    int n;
    send(8'h97, 8'h00, 1'b0, a);
    chk("fstore", 8'h01, 8'(nfs));
    nbr = 0;
    send(8'h96, 8'h00, 1'b0, a);
    boot_wait();
    chk("reboot", 8'h01, 8'(nrb));
    chk("boot_rd", 8'h6F, 8'(nbr));
    chk("ptr", 8'h00, ptr);
    hdr(pin, 1'b0, a);
    i_smb_master_model.put(8'h95, a);
    hdr(pin, 1'b1, a);
    i_smb_master_model.get(1'b1, d);
    chk("blk_count", 8'h10, d);
    i_smb_master_model.get(1'b0, d);
    i_smb_master_model.stop();
    chk("blk_data", 8'h5A, d);
    n = nwr;
    hdr(pin, 1'b0, a);
    for (int i = 0; i < 4; i++) i_smb_master_model.put(i == 0 ? 8'h94 : 8'(i + 1), a);
    i_smb_master_model.stop();
    chk("blk_ack", 8'h01, 8'(a));
    chk("blk_wr", 8'(n + 2), 8'(nwr));
  endtask : t_cmds

  initial begin
    rst = 1'b1;
    repeat (12) @(posedge mclk);
    rst <= #1 1'b0;
    boot_wait();
    t_addr();
    t_send();
    t_page();
    t_read();
    t_cmds();
    stop_test();
  end
endmodule : test_i2c_smbus_slave_port
